/* File: pkg/eio_map.svh */
// register map, field positions, reset values and timing figures of the expansion i/o block
`ifndef EIO_MAP_SVH
`define EIO_MAP_SVH

// register byte offsets
`define EIO_OFF_CTRL      8'h00
`define EIO_OFF_FBSEL     8'h04
`define EIO_OFF_AINA_TYPE 8'h08
`define EIO_OFF_AINA_GAIN 8'h0c
`define EIO_OFF_AINA_OFS  8'h10
`define EIO_OFF_AINB_GAIN 8'h14
`define EIO_OFF_AINB_OFS  8'h18
`define EIO_OFF_AINA_VAL  8'h1c
`define EIO_OFF_AINB_VAL  8'h20
`define EIO_OFF_STATUS    8'h24
`define EIO_OFF_WORD_A    8'h28
`define EIO_OFF_WORD_B    8'h2c
`define EIO_OFF_WORD_C    8'h30

// control register fields
`define EIO_CTRL_SRC_LSB  0
`define EIO_CTRL_SRC_MSB  2
`define EIO_CTRL_POL_BIT  3
`define EIO_CTRL_DIAG_BIT 4
`define EIO_CTRL_NET_BIT  5

// reset values
`define EIO_RST_SRC   3'h1
`define EIO_RST_GAIN  12'h3e8
`define EIO_RST_OFS   9'h000

// tunable limits, gain in thousandths
`define EIO_GAIN_MIN  16'h02ee
`define EIO_GAIN_MAX  16'h08ca
`define EIO_OFS_MAX   16'h00c8
`define EIO_OFS_MIN   16'hff38

// converter scale: full scale and range low points
`define EIO_FSV       17'h007ff
`define EIO_LOW_V0    13'h0000
`define EIO_LOW_BIP   13'h1801
`define EIO_LOW_MA    13'h0199

// divide by 1000 as multiply by 1049 then shift 20
`define EIO_RECIP     37'h0000000419
`define EIO_RECIP_SH  20

// sample periods
`define EIO_CLK_MHZ   250
`define EIO_FAST_MS   5
`define EIO_SLOW_MS   10
`define EIO_FAST_CYC  (`EIO_FAST_MS * 1000 * `EIO_CLK_MHZ)
`define EIO_SLOW_CYC  (`EIO_SLOW_MS * 1000 * `EIO_CLK_MHZ)
`define EIO_TMR_W     22

`endif

/* File: pkg/eio_pkg.sv */
// types shared by the expansion i/o block
package eio_pkg;
    typedef enum logic [2:0] {
        src_level_det_1, src_level_det_2, src_in_current_limit, src_drive_ready,
        src_link_health, src_remote_word_a, src_remote_word_b, src_remote_word_c
    } eio_src_t;
    typedef enum logic [1:0] {
        dc_tachometer_fb, pulse_tachometer_fb, ac_tachometer_fb, armature_voltage_fb
    } eio_fb_t;
    typedef enum logic [1:0] {
        rng_0_10v, rng_pm_10v, rng_4_20ma, rng_10_50ma
    } eio_rng_t;
endpackage

/* File: verilog/eio_sample_timer.sv */
// sample period timer, 5 or 10 ms by speed feedback choice
`timescale 1ns/1ns
`default_nettype none
`include "eio_map.svh"
module eio_sample_timer #(
    parameter int unsigned FAST_CYC = `EIO_FAST_CYC,
    parameter int unsigned SLOW_CYC = `EIO_SLOW_CYC
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // period select and tick
    input  wire logic slow,
    output var  logic tick
);
    logic [`EIO_TMR_W-1:0] cnt_ff;
    logic [`EIO_TMR_W-1:0] lim;
    logic                  tick_ff;

    // last count of the running period
    assign lim  = slow ? `EIO_TMR_W'(SLOW_CYC - 1) : `EIO_TMR_W'(FAST_CYC - 1);
    assign tick = tick_ff;

    // free counter, wraps at the limit or beyond it after a shorter choice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (cnt_ff >= lim) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/eio_ain_scale.sv */
// analog input conditioning: range clamp, zero offset, gain, saturation
`timescale 1ns/1ns
`default_nettype none
`include "eio_map.svh"
module eio_ain_scale import eio_pkg::*; (
    // raw converter sample and settings
    input  wire logic        [11:0] raw,
    input  wire eio_rng_t           rng,
    input  wire logic signed [8:0]  ofs,
    input  wire logic        [11:0] gain,
    // scaled value
    output var  logic signed [15:0] value
);
    logic signed [12:0] low;
    logic signed [12:0] raw_x;
    logic signed [12:0] clip;
    logic signed [12:0] z;
    logic signed [13:0] s;
    logic        [13:0] mag;
    logic        [36:0] prod;
    logic        [16:0] q;
    logic        [11:0] sat;
    logic               is_ma;

    // low point of range, current loops report zero at their low point
    always_comb begin
        is_ma = (rng == rng_4_20ma) || (rng == rng_10_50ma);
        unique case (rng)
            rng_0_10v:   low = `EIO_LOW_V0;
            rng_pm_10v:  low = `EIO_LOW_BIP;
            rng_4_20ma:  low = `EIO_LOW_MA;
            rng_10_50ma: low = `EIO_LOW_MA;
        endcase
    end

    // clamp, remove zero offset, scale magnitude, saturate
    always_comb begin
        raw_x = {raw[11], raw};
        clip  = (raw_x < low) ? low : raw_x;
        z     = is_ma ? 13'(clip - low) : clip;
        s     = 14'({z[12], z} + {{5{ofs[8]}}, ofs});
        mag   = s[13] ? 14'(-s) : s;
        prod  = 37'(37'(mag) * 37'(gain)) * `EIO_RECIP;
        q     = prod[`EIO_RECIP_SH +: 17];
        sat   = (q > `EIO_FSV) ? 12'(`EIO_FSV) : q[11:0];
        value = s[13] ? 16'(-$signed({4'h0, sat})) : $signed({4'h0, sat});
    end
endmodule
`default_nettype wire

/* File: verilog/eio_top.sv */
// expansion i/o: output 2 source select and analog input scaling behind apb
//
// Contract
// - output 2 driven by one selectable source
// - remote word source uses bit zero
// - remote words update only network control, link
// - drive-ready source follows run-ready flag
// - current-limit source follows current limit flag
// - tachometer feedback samples inputs every 5 ms
// - armature voltage feedback samples every 10 ms
// - input a signal type selectable, default bipolar
// - below range uses range low point
// - input b bipolar ten volt only
// - gain 0.750 to 2.250, default 1.000
// - zero offset -200 to 200, default 0
// - scaled values readable after offset, gain
// - gain below one loses resolution, uncompensated
// - polarity: open off normally, inverted option
// - contact open until diagnostics complete
`timescale 1ns/1ns
`default_nettype none
`include "eio_map.svh"
module eio_top import eio_pkg::*; #(
    parameter int unsigned FAST_CYC = `EIO_FAST_CYC,
    parameter int unsigned SLOW_CYC = `EIO_SLOW_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // drive status flags
    input  wire logic        level_det_1,
    input  wire logic        level_det_2,
    input  wire logic        in_current_limit,
    input  wire logic        drive_ready,
    // network side
    input  wire logic        link_health_flag,
    input  wire logic        link_active,
    input  wire logic [15:0] remote_word_in_a,
    input  wire logic [15:0] remote_word_in_b,
    input  wire logic [15:0] remote_word_in_c,
    // converter samples
    input  wire logic [11:0] ain_a_raw,
    input  wire logic [11:0] ain_b_raw,
    output var  logic        ain_sample_req,
    // contact output
    output var  logic        out2_contact_closed
);
    eio_src_t           out2_source_select_ff;
    logic               out2_contact_polarity_ff;
    logic               diag_done_ff;
    logic               net_ctrl_ff;
    eio_fb_t            speed_feedback_choice_ff;
    eio_rng_t           ain_a_range_type_ff;
    logic        [11:0] gain_ff [2];
    logic signed [8:0]  ofs_ff [2];
    logic signed [15:0] val_ff [2];
    logic signed [15:0] scaled [2];
    logic        [11:0] raw_in [2];
    eio_rng_t           rng_in [2];
    logic        [15:0] word_ff [3];
    logic        [15:0] word_in [3];
    logic               contact_ff;
    logic               src_on;
    logic               word_upd;
    logic               tick;
    logic        [31:0] prdata_ff;
    logic        [31:0] nxt_prdata;
    logic               wr_en;
    logic               rd_setup;

    // known register offsets
    function automatic logic addr_ok(input logic [7:0] a);
        unique case (a)
            `EIO_OFF_CTRL, `EIO_OFF_FBSEL, `EIO_OFF_AINA_TYPE,
            `EIO_OFF_AINA_GAIN, `EIO_OFF_AINA_OFS, `EIO_OFF_AINB_GAIN,
            `EIO_OFF_AINB_OFS, `EIO_OFF_AINA_VAL, `EIO_OFF_AINB_VAL,
            `EIO_OFF_STATUS, `EIO_OFF_WORD_A, `EIO_OFF_WORD_B,
            `EIO_OFF_WORD_C: addr_ok = 1'b1;
            default:         addr_ok = 1'b0;
        endcase
    endfunction

    // gain write limited to its tunable span
    function automatic logic [11:0] clamp_gain(input logic [15:0] d);
        if (d < `EIO_GAIN_MIN) begin
            clamp_gain = 12'(`EIO_GAIN_MIN);
        end else if (d > `EIO_GAIN_MAX) begin
            clamp_gain = 12'(`EIO_GAIN_MAX);
        end else begin
            clamp_gain = d[11:0];
        end
    endfunction

    // offset write limited to its tunable span
    function automatic logic signed [8:0] clamp_ofs(input logic [15:0] d);
        if ($signed(d) > $signed(`EIO_OFS_MAX)) begin
            clamp_ofs = 9'(`EIO_OFS_MAX);
        end else if ($signed(d) < $signed(`EIO_OFS_MIN)) begin
            clamp_ofs = 9'(`EIO_OFS_MIN);
        end else begin
            clamp_ofs = d[8:0];
        end
    endfunction

    // apb strobes, zero wait states
    assign wr_en    = psel & penable & pwrite & addr_ok(paddr);
    assign rd_setup = psel & ~penable;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_ok(paddr);
    assign prdata   = prdata_ff;

    // control register: source, polarity, network control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out2_source_select_ff    <= eio_src_t'(`EIO_RST_SRC);
            out2_contact_polarity_ff <= 1'b0;
            net_ctrl_ff              <= 1'b0;
        end else if (wr_en && paddr == `EIO_OFF_CTRL) begin
            out2_source_select_ff    <= eio_src_t'(pwdata[`EIO_CTRL_SRC_MSB:`EIO_CTRL_SRC_LSB]);
            out2_contact_polarity_ff <= pwdata[`EIO_CTRL_POL_BIT];
            net_ctrl_ff              <= pwdata[`EIO_CTRL_NET_BIT];
        end
    end

    // diagnostics done: set once by software, cleared only by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag_done_ff <= 1'b0;
        end else if (wr_en && paddr == `EIO_OFF_CTRL && pwdata[`EIO_CTRL_DIAG_BIT]) begin
            diag_done_ff <= 1'b1;
        end
    end

    // speed feedback choice and input a signal type
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_feedback_choice_ff <= dc_tachometer_fb;
            ain_a_range_type_ff      <= rng_pm_10v;
        end else begin
            if (wr_en && paddr == `EIO_OFF_FBSEL) begin
                speed_feedback_choice_ff <= eio_fb_t'(pwdata[1:0]);
            end
            if (wr_en && paddr == `EIO_OFF_AINA_TYPE) begin
                ain_a_range_type_ff <= eio_rng_t'(pwdata[1:0]);
            end
        end
    end

    // sample period follows speed feedback choice
    eio_sample_timer #(
        .FAST_CYC (FAST_CYC),
        .SLOW_CYC (SLOW_CYC)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .slow    (speed_feedback_choice_ff == armature_voltage_fb),
        .tick    (tick)
    );
    assign ain_sample_req = tick;

    // channel wiring, input b fixed bipolar
    assign raw_in[0] = ain_a_raw;
    assign raw_in[1] = ain_b_raw;
    assign rng_in[0] = ain_a_range_type_ff;
    assign rng_in[1] = rng_pm_10v;

    // per channel tunables, scaling and held value
    for (genvar ch = 0; ch < 2; ch++) begin : g_ain
        localparam logic [7:0] GAIN_OFF = (ch == 0) ? `EIO_OFF_AINA_GAIN : `EIO_OFF_AINB_GAIN;
        localparam logic [7:0] OFS_OFF  = (ch == 0) ? `EIO_OFF_AINA_OFS : `EIO_OFF_AINB_OFS;

        // gain and zero offset, clamped on write
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                gain_ff[ch] <= `EIO_RST_GAIN;
                ofs_ff[ch]  <= `EIO_RST_OFS;
            end else begin
                if (wr_en && paddr == GAIN_OFF) begin
                    gain_ff[ch] <= clamp_gain(pwdata[15:0]);
                end
                if (wr_en && paddr == OFS_OFF) begin
                    ofs_ff[ch] <= clamp_ofs(pwdata[15:0]);
                end
            end
        end

        eio_ain_scale u_scale (
            .raw   (raw_in[ch]),
            .rng   (rng_in[ch]),
            .ofs   (ofs_ff[ch]),
            .gain  (gain_ff[ch]),
            .value (scaled[ch])
        );

        // value taken once per sample period
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                val_ff[ch] <= '0;
            end else if (tick) begin
                val_ff[ch] <= scaled[ch];
            end
        end
    end

    // remote words follow the link only under network control
    assign word_in[0] = remote_word_in_a;
    assign word_in[1] = remote_word_in_b;
    assign word_in[2] = remote_word_in_c;
    assign word_upd   = net_ctrl_ff & link_active;

    for (genvar w = 0; w < 3; w++) begin : g_word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                word_ff[w] <= '0;
            end else if (word_upd) begin
                word_ff[w] <= word_in[w];
            end
        end
    end

    // output 2 source selection
    always_comb begin
        unique case (out2_source_select_ff)
            src_level_det_1:      src_on = level_det_1;
            src_level_det_2:      src_on = level_det_2;
            src_in_current_limit: src_on = in_current_limit;
            src_drive_ready:      src_on = drive_ready;
            src_link_health:      src_on = link_health_flag;
            src_remote_word_a:    src_on = word_ff[0][0];
            src_remote_word_b:    src_on = word_ff[1][0];
            src_remote_word_c:    src_on = word_ff[2][0];
        endcase
    end

    // contact state: polarity, held open before diagnostics
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contact_ff <= 1'b0;
        end else begin
            contact_ff <= diag_done_ff & (src_on ^ out2_contact_polarity_ff);
        end
    end
    assign out2_contact_closed = contact_ff;

    // read mux
    always_comb begin
        nxt_prdata = '0;
        unique case (paddr)
            `EIO_OFF_CTRL: begin
                nxt_prdata[`EIO_CTRL_SRC_MSB:`EIO_CTRL_SRC_LSB] = out2_source_select_ff;
                nxt_prdata[`EIO_CTRL_POL_BIT]  = out2_contact_polarity_ff;
                nxt_prdata[`EIO_CTRL_DIAG_BIT] = diag_done_ff;
                nxt_prdata[`EIO_CTRL_NET_BIT]  = net_ctrl_ff;
            end
            `EIO_OFF_FBSEL:     nxt_prdata[1:0] = speed_feedback_choice_ff;
            `EIO_OFF_AINA_TYPE: nxt_prdata[1:0] = ain_a_range_type_ff;
            `EIO_OFF_AINA_GAIN: nxt_prdata[11:0] = gain_ff[0];
            `EIO_OFF_AINB_GAIN: nxt_prdata[11:0] = gain_ff[1];
            `EIO_OFF_AINA_OFS:  nxt_prdata = 32'($signed(ofs_ff[0]));
            `EIO_OFF_AINB_OFS:  nxt_prdata = 32'($signed(ofs_ff[1]));
            `EIO_OFF_AINA_VAL:  nxt_prdata = 32'($signed(val_ff[0]));
            `EIO_OFF_AINB_VAL:  nxt_prdata = 32'($signed(val_ff[1]));
            `EIO_OFF_STATUS:    nxt_prdata[2:0] = {word_upd, src_on, contact_ff};
            `EIO_OFF_WORD_A:    nxt_prdata[15:0] = word_ff[0];
            `EIO_OFF_WORD_B:    nxt_prdata[15:0] = word_ff[1];
            `EIO_OFF_WORD_C:    nxt_prdata[15:0] = word_ff[2];
            default:            nxt_prdata = '0;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (rd_setup) begin
            prdata_ff <= addr_ok(paddr) ? nxt_prdata : '0;
        end
    end
endmodule
`default_nettype wire

/* File: sim/eio_top_assertions.sv */
// concurrent checks on the expansion i/o top ports
`timescale 1ns/1ns
`default_nettype none
module eio_top_checker #(
    parameter int unsigned FAST_CYC = 20,
    parameter int unsigned SLOW_CYC = 40
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // drive flags
    input wire logic        level_det_1,
    input wire logic        level_det_2,
    input wire logic        in_current_limit,
    input wire logic        drive_ready,
    // network side
    input wire logic        link_health_flag,
    input wire logic        link_active,
    input wire logic [15:0] remote_word_in_a,
    input wire logic [15:0] remote_word_in_b,
    input wire logic [15:0] remote_word_in_c,
    // converter and contact
    input wire logic [11:0] ain_a_raw,
    input wire logic [11:0] ain_b_raw,
    input wire logic        ain_sample_req,
    input wire logic        out2_contact_closed
);
    logic [5:0]  ctrl_ff;
    logic [1:0]  fb_ff;
    logic        steady_ff;
    logic [31:0] cnt_ff;
    logic [7:0]  lv;
    logic        acc;
    logic        unmapped;
    // decoded access, unmapped offset and the levels of the five sources that are not remote words
    assign acc      = psel && penable;
    assign unmapped = paddr[1:0] != 2'h0 || paddr > 8'h30;
    assign lv       = {3'h0, link_health_flag, drive_ready, in_current_limit, level_det_2, level_det_1};
    // shadow of the control word; diagnostics bit only sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 6'h01;
        end else if (acc && pwrite && paddr == 8'h00) begin
            ctrl_ff <= {pwdata[5], pwdata[4] | ctrl_ff[4], pwdata[3:0]};
        end
    end
    // feedback shadow and cycles since last sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_ff <= 2'h0;
            steady_ff <= 1'b0;
            cnt_ff <= 32'h0;
        end else begin
            fb_ff <= (acc && pwrite && paddr == 8'h04) ? pwdata[1:0] : fb_ff;
            steady_ff <= (acc && pwrite && paddr == 8'h04) ? 1'b0 : (ain_sample_req | steady_ff);
            cnt_ff <= ain_sample_req ? 32'h1 : cnt_ff + 32'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_slverr;
        acc |-> pslverr == unmapped;
    endproperty
    a_slverr: assert property (p_slverr) else $error("error response wrong");
    property p_unmapped_rd;
        acc && !pwrite && unmapped |-> prdata == 32'h0;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
    property p_ctrl_rd;
        acc && !pwrite && paddr == 8'h00 |-> prdata == {26'h0, $past(ctrl_ff)};
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
    property p_diag_gate;
        !ctrl_ff[4] |-> !out2_contact_closed;
    endproperty
    a_diag_gate: assert property (p_diag_gate) else $error("contact closed before diagnostics");
    property p_contact;
        $past(ctrl_ff[4] && ctrl_ff[2:0] < 3'h5) |-> out2_contact_closed == $past(lv[ctrl_ff[2:0]] ^ ctrl_ff[3]);
    endproperty
    a_contact: assert property (p_contact) else $error("contact level wrong");
    property p_pulse;
        ain_sample_req |=> !ain_sample_req;
    endproperty
    a_pulse: assert property (p_pulse) else $error("sample pulse too long");
    property p_period;
        ain_sample_req && steady_ff |-> cnt_ff == (fb_ff == 2'h3 ? SLOW_CYC : FAST_CYC);
    endproperty
    a_period: assert property (p_period) else $error("sample period wrong");
    property p_status_rd;
        acc && !pwrite && paddr == 8'h24 |-> prdata[0] == $past(out2_contact_closed);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status contact bit wrong");
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase not completed");
endmodule
bind eio_top eio_top_checker #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .level_det_1(level_det_1), .level_det_2(level_det_2), .in_current_limit(in_current_limit),
    .drive_ready(drive_ready), .link_health_flag(link_health_flag), .link_active(link_active),
    .remote_word_in_a(remote_word_in_a), .remote_word_in_b(remote_word_in_b),
    .remote_word_in_c(remote_word_in_c), .ain_a_raw(ain_a_raw), .ain_b_raw(ain_b_raw),
    .ain_sample_req(ain_sample_req), .out2_contact_closed(out2_contact_closed)
);
`default_nettype wire

/* File: sim/eio_field_model.sv */
// field wiring model: converter codes settle only in the sample cycle
`timescale 1ns/1ns
`default_nettype none
module eio_field_model (
    // clock and sample request
    input  wire logic        pclk,
    input  wire logic        ain_sample_req,
    // levels at the terminals
    input  wire logic [11:0] level_a,
    input  wire logic [11:0] level_b,
    // converter codes
    output var  logic [11:0] ain_a_raw,
    output var  logic [11:0] ain_b_raw
);
    logic [11:0] churn_ff = 12'h000;
    // churn outside the sample so a stale capture shows
    always_ff @(posedge pclk) begin
        churn_ff <= churn_ff + 12'h5a3;
    end
    // settled code only while a sample is taken
    always_comb begin
        ain_a_raw = ain_sample_req ? level_a : churn_ff;
        ain_b_raw = ain_sample_req ? level_b : ~churn_ff;
    end
endmodule
`default_nettype wire

/* File: sim/eio_top_bench.sv */
// self-checking bench for the expansion i/o top
`timescale 1ns/1ns
`default_nettype none
module eio_top_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, link_active = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, ain_sample_req, out2_contact_closed, pol, lv;
    logic [4:0]  flags = 5'h0;
    logic [15:0] word_in [3] = '{16'h0, 16'h0, 16'h0};
    logic [11:0] lvl_a = 12'h0, lvl_b = 12'h0, ain_a_raw, ain_b_raw;
    logic [47:0] wv;
    logic [31:0] exp_q [$];
    logic [31:0] rst_val [13] = '{32'h1, 32'h0, 32'h1, 32'h3e8, 32'h0, 32'h3e8, 32'h0, 32'h0, 32'h0,
                                  32'h0, 32'h0, 32'h0, 32'h0};
    int          cs [10][4] = '{'{-500, 0, 0, 1000}, '{300, 2, 0, 1000}, '{1000, 3, -200, 750},
                                '{800, 1, 200, 2250}, '{2000, 1, 100, 2250}, '{-2048, 1, -200, 2250},
                                '{0, 0, 0, 0}, '{0, 0, 0, 0}, '{0, 0, 0, 0}, '{0, 0, 0, 0}};
    int          miscompares = 0;
    int          tests_run = 0;
    int          src;
    always #2 pclk = ~pclk;
    eio_top #(.FAST_CYC(20), .SLOW_CYC(40)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .level_det_1(flags[0]), .level_det_2(flags[1]), .in_current_limit(flags[2]),
        .drive_ready(flags[3]), .link_health_flag(flags[4]), .link_active(link_active),
        .remote_word_in_a(word_in[0]), .remote_word_in_b(word_in[1]), .remote_word_in_c(word_in[2]),
        .ain_a_raw(ain_a_raw), .ain_b_raw(ain_b_raw), .ain_sample_req(ain_sample_req),
        .out2_contact_closed(out2_contact_closed)
    );
    eio_field_model field (
        .pclk(pclk), .ain_sample_req(ain_sample_req), .level_a(lvl_a), .level_b(lvl_b),
        .ain_a_raw(ain_a_raw), .ain_b_raw(ain_b_raw)
    );
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one apb transfer: setup, then access held until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        xfer(1'b1, a, 32'(d));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    // wait for a sample pulse, then for the edge that loads it
    task automatic wait_sample();
        do begin
            @(negedge pclk);
        end while (ain_sample_req !== 1'b1);
        @(posedge pclk);
    endtask
    function automatic logic [31:0] exp_val(input int r, input int t, input int o, input int g);
        int     lo;
        longint s, m;
        lo = (t == 0) ? 0 : (t == 1) ? -2047 : 409;
        s = ((r < lo) ? lo : r) - ((t > 1) ? 409 : 0) + o;
        m = (((s < 0) ? -s : s) * g * 1049) >> 20;
        m = (m > 2047) ? 2047 : m;
        return 32'((s < 0) ? -m : m);
    endfunction
    // read results against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check(prdata, exp_q.pop_front());
        end
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        void'($urandom(32'h2544));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++) rd(8'(i * 4), rst_val[i]);
        rd(8'h34, 32'h0);
        rd(8'h1e, 32'h0);
        wr(8'h1c, 32'h7ff);
        wr(8'h28, 32'hffff);
        rd(8'h1c, 32'h0);
        rd(8'h28, 32'h0);
        @(posedge pclk);
        flags <= 5'h02;
        rd(8'h24, 32'h2);
        wr(8'h00, 32'h11);
        rd(8'h24, 32'h3);
        wr(8'h00, 32'h31);
        @(posedge pclk);
        link_active <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            src = i % 8;
            pol = 1'(i / 8);
            wv = 48'({$urandom, $urandom});
            @(posedge pclk);
            flags <= 5'($urandom);
            for (int k = 0; k < 3; k++) word_in[k] <= wv[k * 16 +: 16];
            @(posedge pclk);
            lv = (src < 5) ? flags[src] : wv[(src - 5) * 16];
            wr(8'h00, 32'({2'h3, pol, 3'(src)}));
            rd(8'h00, 32'({2'h3, pol, 3'(src)}));
            rd(8'h24, 32'({1'b1, lv, lv ^ pol}));
        end
        @(posedge pclk);
        word_in[0] <= 16'h1234;
        rd(8'h28, 32'h1234);
        link_active <= 1'b0;
        word_in[0] <= 16'hbeef;
        rd(8'h28, 32'h1234);
        wr(8'h00, 32'h11);
        link_active <= 1'b1;
        word_in[0] <= 16'h5555;
        rd(8'h28, 32'h1234);
        wr(8'h0c, 32'h64);
        rd(8'h0c, 32'h2ee);
        wr(8'h10, 32'hfed4);
        rd(8'h10, 32'hffffff38);
        wr(8'h10, 32'h12c);
        rd(8'h10, 32'hc8);
        for (int i = 6; i < 10; i++) begin
            cs[i] = '{int'($urandom_range(4095)) - 2048, int'($urandom_range(3)),
                      int'($urandom_range(400)) - 200, int'($urandom_range(2250, 750))};
        end
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            lvl_a <= 12'(cs[i][0]);
            lvl_b <= ~12'(cs[i][0]);
            wr(8'h08, cs[i][1]);
            wr(8'h10, cs[i][2]);
            wr(8'h18, cs[i][2]);
            wr(8'h0c, cs[i][3]);
            wr(8'h14, cs[i][3]);
            wait_sample();
            rd(8'h1c, exp_val(cs[i][0], cs[i][1], cs[i][2], cs[i][3]));
            rd(8'h20, exp_val(int'($signed(lvl_b)), 1, cs[i][2], cs[i][3]));
        end
        for (int f = 0; f < 4; f++) begin
            wr(8'h04, f);
            rd(8'h04, 32'(f));
            repeat (3) wait_sample();
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
